// file: core/comm_channel_data_lanes.sv
// data lane mapping of the fast channel onto the shared port pins
`timescale 1ns/1ps
`include "lanes_cfg.svh"

module comm_channel_data_lanes (
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          nrst,
  // lane selection
  input  wire lanes_pkg::lane_mode_type      lane_mode,
  input  wire logic [`LANES_TAG_W-1:0]       dma_tag_pin_sel,
  // shared port pins
  input  wire logic [`LANES_PIN_COUNT-1:0]   pin_in,
  output logic      [`LANES_PIN_COUNT-1:0]   pin_out,
  output logic      [`LANES_PIN_COUNT-1:0]   pin_oe,
  // receive link controls from the phy
  input  wire logic                          rx_bus_enable,
  input  wire logic                          rx_cell_start,
  // transmit stream
  input  wire logic                          tx_valid,
  input  wire logic [`LANES_OCTET_W-1:0]     tx_data,
  output logic                               tx_ready,
  output logic                               tx_active,
  output logic                               tx_cell_first,
  // receive stream
  output logic                               rx_valid,
  output logic      [`LANES_OCTET_W-1:0]     rx_data,
  output logic                               rx_cell_first,
  output logic                               rx_cell_last,
  output logic                               rx_cell_error,
  // serial dma requester
  input  wire logic [`LANES_SUB_BLOCK_W-1:0] dma_sub_block,
  input  wire logic                          dma_is_receive,
  input  wire logic                          dma_error,
  input  wire logic                          dma_error_clear,
  output logic      [`LANES_TAG_W-1:0]       dma_error_tag,
  output logic                               dma_error_flag
);

  typedef struct packed {
    lanes_pkg::tx_state_type           tx_state;
    logic [5:0]                        tx_octet;
    logic [`LANES_OCTET_W-1:0]         tx_line;
    logic [`LANES_OCTET_W-1:0]         tx_shift;
    logic [3:0]                        tx_units;
    logic                              tx_active;
    logic                              tx_first;
    logic                              rx_take;
    logic [`LANES_OCTET_W-1:0]         rx_shift;
    logic [3:0]                        rx_units;
    logic [5:0]                        rx_octet;
    logic                              rx_valid;
    logic [`LANES_OCTET_W-1:0]         rx_data;
    logic                              rx_first;
    logic                              rx_last;
    logic                              rx_error;
    logic [`LANES_PIN_COUNT-1:0]       pin_out;
    logic [`LANES_PIN_COUNT-1:0]       pin_oe;
    logic [`LANES_TAG_W-1:0]           err_tag;
    logic                              err_flag;
  } core_state_type;

  core_state_type                st;
  core_state_type                next_st;
  logic [`LANES_PIN_COUNT+1:0]   sync_raw;
  logic [`LANES_PIN_COUNT+1:0]   sync_val;
  logic [`LANES_PIN_COUNT-1:0]   pins_s;
  logic                          rx_en_s;
  logic                          rx_soc_s;
  logic                          fifo_valid;
  logic [`LANES_OCTET_W-1:0]     fifo_data;
  logic                          fifo_pop;
  logic [`LANES_TAG_W-1:0]       tag_now;
  logic                          cell_start;

  // pin carrying a given tag bit
  function automatic int tag_pin(input int bit_no);
    case (bit_no)
      0:       tag_pin = 15;
      1:       tag_pin = 14;
      2:       tag_pin = 3;
      3:       tag_pin = 2;
      4:       tag_pin = 1;
      default: tag_pin = 0;
    endcase
  endfunction

  assign sync_raw = {rx_cell_start, rx_bus_enable, pin_in};

  lane_sync #(
    .WIDTH (`LANES_PIN_COUNT + 2)
  ) u_sync (
    .mclk     (mclk),
    .nrst     (nrst),
    .async_in (sync_raw),
    .sync_out (sync_val)
  );

  assign pins_s   = sync_val[`LANES_PIN_COUNT-1:0];
  assign rx_en_s  = sync_val[`LANES_PIN_COUNT];
  assign rx_soc_s = sync_val[`LANES_PIN_COUNT+1];

  lane_fifo #(
    .WIDTH (`LANES_OCTET_W),
    .DEPTH (`LANES_FIFO_DEPTH)
  ) u_tx_fifo (
    .mclk      (mclk),
    .nrst      (nrst),
    .in_valid  (tx_valid),
    .in_data   (tx_data),
    .in_ready  (tx_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_pop)
  );

  assign tag_now    = {dma_is_receive, dma_sub_block};
  assign cell_start = (st.tx_state != lanes_pkg::TX_CELL_DATA &&
                       st.tx_state != lanes_pkg::TX_CELL_IDLE) ||
                      (st.tx_octet == `LANES_CELL_LAST);

  always_comb begin
    logic [5:0] rx_count;
    logic [3:0] unit;
    next_st          = st;
    fifo_pop         = 1'b0;
    rx_count         = st.rx_octet;
    unit             = 4'h0;
    next_st.rx_valid = 1'b0;
    next_st.rx_first = 1'b0;
    next_st.rx_last  = 1'b0;
    next_st.rx_error = 1'b0;
    next_st.tx_first = 1'b0;

    // transmit sequencing
    unique case (lane_mode)
      lanes_pkg::MODE_CELL: begin
        next_st.tx_active = 1'b1;
        if (cell_start) begin
          next_st.tx_octet = `LANES_RST_COUNT;
          next_st.tx_first = 1'b1;
          if (fifo_valid) begin
            next_st.tx_state = lanes_pkg::TX_CELL_DATA;
          end else begin
            next_st.tx_state = lanes_pkg::TX_CELL_IDLE;
          end
        end else begin
          next_st.tx_octet = st.tx_octet + 6'h01;
        end
        if (next_st.tx_state == lanes_pkg::TX_CELL_DATA) begin
          if (fifo_valid) begin
            fifo_pop        = 1'b1;
            next_st.tx_line = fifo_data;
          end else begin
            next_st.tx_line = `LANES_FILL_OCTET;
          end
        end else begin
          next_st.tx_line = `LANES_IDLE_OCTET;
        end
      end
      lanes_pkg::MODE_NIBBLE, lanes_pkg::MODE_SERIAL: begin
        next_st.tx_state = lanes_pkg::TX_STREAM;
        next_st.tx_octet = `LANES_RST_COUNT;
        if (st.tx_units != `LANES_RST_UNITS) begin
          unit              = st.tx_shift[3:0];
          next_st.tx_active = 1'b1;
          next_st.tx_units  = st.tx_units - 4'h1;
          next_st.tx_shift  = (lane_mode == lanes_pkg::MODE_NIBBLE) ?
                              {4'h0, st.tx_shift[7:4]} : {1'b0, st.tx_shift[7:1]};
        end else if (fifo_valid) begin
          fifo_pop          = 1'b1;
          unit              = fifo_data[3:0];
          next_st.tx_active = 1'b1;
          if (lane_mode == lanes_pkg::MODE_NIBBLE) begin
            next_st.tx_units = `LANES_NIBBLE_UNITS - 4'h1;
            next_st.tx_shift = {4'h0, fifo_data[7:4]};
          end else begin
            next_st.tx_units = `LANES_SERIAL_UNITS - 4'h1;
            next_st.tx_shift = {1'b0, fifo_data[7:1]};
          end
        end else begin
          next_st.tx_active = 1'b0;
        end
        if (lane_mode == lanes_pkg::MODE_NIBBLE) begin
          next_st.tx_line = {4'h0, unit};
        end else begin
          next_st.tx_line = {7'h00, unit[0]};
        end
      end
      lanes_pkg::MODE_OFF: begin
        next_st.tx_state  = lanes_pkg::TX_OFF;
        next_st.tx_octet  = `LANES_RST_COUNT;
        next_st.tx_units  = `LANES_RST_UNITS;
        next_st.tx_line   = `LANES_RST_OCTET;
        next_st.tx_active = 1'b0;
      end
    endcase

    // receive: enable seen this cycle, lines taken at the end of the next
    next_st.rx_take = rx_en_s;
    if (st.rx_take) begin
      unique case (lane_mode)
        lanes_pkg::MODE_CELL: begin
          next_st.rx_valid = 1'b1;
          next_st.rx_data  = pins_s[7:0];
          if (rx_soc_s) begin
            next_st.rx_error = (st.rx_octet != `LANES_RST_COUNT);
            rx_count         = 6'h01;
          end else begin
            rx_count         = st.rx_octet + 6'h01;
          end
          next_st.rx_first = (rx_count == 6'h01);
          next_st.rx_last  = (rx_count == `LANES_CELL_OCTETS);
          next_st.rx_octet = next_st.rx_last ? `LANES_RST_COUNT : rx_count;
        end
        lanes_pkg::MODE_NIBBLE: begin
          next_st.rx_shift = {pins_s[4], pins_s[5], pins_s[6],
                              pins_s[`LANES_PIN_NIB_RX_B0], st.rx_shift[7:4]};
          next_st.rx_units = st.rx_units + 4'h1;
          if (next_st.rx_units == `LANES_NIBBLE_UNITS) begin
            next_st.rx_valid = 1'b1;
            next_st.rx_data  = next_st.rx_shift;
            next_st.rx_units = `LANES_RST_UNITS;
          end
        end
        lanes_pkg::MODE_SERIAL: begin
          next_st.rx_shift = {pins_s[`LANES_PIN_SER_RX], st.rx_shift[7:1]};
          next_st.rx_units = st.rx_units + 4'h1;
          if (next_st.rx_units == `LANES_SERIAL_UNITS) begin
            next_st.rx_valid = 1'b1;
            next_st.rx_data  = next_st.rx_shift;
            next_st.rx_units = `LANES_RST_UNITS;
          end
        end
        lanes_pkg::MODE_OFF: begin
          next_st.rx_units = `LANES_RST_UNITS;
          next_st.rx_octet = `LANES_RST_COUNT;
        end
      endcase
    end
    if (lane_mode != lanes_pkg::MODE_CELL) begin
      next_st.rx_octet = `LANES_RST_COUNT;
    end
    // partial stream units dropped whenever the lanes are off
    if (lane_mode == lanes_pkg::MODE_OFF) begin
      next_st.rx_units = `LANES_RST_UNITS;
    end

    // pin function per mode
    next_st.pin_out = `LANES_RST_PINS;
    next_st.pin_oe  = `LANES_RST_PINS;
    unique case (lane_mode)
      lanes_pkg::MODE_CELL: begin
        for (int i = 0; i < 8; i++) begin
          next_st.pin_out[`LANES_PIN_CELL_TX_HI-i] = next_st.tx_line[i];
          next_st.pin_oe[`LANES_PIN_CELL_TX_HI-i]  = 1'b1;
        end
      end
      lanes_pkg::MODE_NIBBLE: begin
        for (int i = 0; i < 4; i++) begin
          next_st.pin_out[`LANES_PIN_NIB_TX_LO+i] = next_st.tx_line[i];
          next_st.pin_oe[`LANES_PIN_NIB_TX_LO+i]  = 1'b1;
        end
      end
      lanes_pkg::MODE_SERIAL: begin
        next_st.pin_out[`LANES_PIN_SER_TX] = next_st.tx_line[0];
        next_st.pin_oe[`LANES_PIN_SER_TX]  = 1'b1;
      end
      lanes_pkg::MODE_OFF: begin
        next_st.pin_oe = `LANES_RST_PINS;
      end
    endcase
    // a tag selection takes the pin over from the lane function
    for (int k = 0; k < `LANES_TAG_W; k++) begin
      if (dma_tag_pin_sel[k]) begin
        next_st.pin_out[tag_pin(k)] = tag_now[k];
        next_st.pin_oe[tag_pin(k)]  = 1'b1;
      end
    end

    // error record, a new error wins over the clear
    if (dma_error) begin
      next_st.err_tag  = tag_now;
      next_st.err_flag = 1'b1;
    end else if (dma_error_clear) begin
      next_st.err_flag = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pin_out        = st.pin_out;
  assign pin_oe         = st.pin_oe;
  assign tx_active      = st.tx_active;
  assign tx_cell_first  = st.tx_first;
  assign rx_valid       = st.rx_valid;
  assign rx_data        = st.rx_data;
  assign rx_cell_first  = st.rx_first;
  assign rx_cell_last   = st.rx_last;
  assign rx_cell_error  = st.rx_error;
  assign dma_error_tag  = st.err_tag;
  assign dma_error_flag = st.err_flag;

  // checks
  property p_cell_wrap;
    @(posedge mclk) disable iff (!nrst)
    (lane_mode == lanes_pkg::MODE_CELL && st.tx_state != lanes_pkg::TX_OFF &&
     st.tx_state != lanes_pkg::TX_STREAM && st.tx_octet == `LANES_CELL_LAST)
    |=> (st.tx_octet == 6'h00 && st.tx_first);
  endproperty
  a_cell_wrap: assert property (p_cell_wrap)
    else $error("cell did not wrap after 53 octets");

  property p_cell_pins;
    @(posedge mclk) disable iff (!nrst)
    (st.tx_state == lanes_pkg::TX_CELL_DATA && $stable(dma_tag_pin_sel) &&
     dma_tag_pin_sel == 6'h00)
    |-> (st.pin_out[15] == st.tx_line[0] && st.pin_out[8] == st.tx_line[7] &&
         st.pin_oe[15:8] == 8'hff);
  endproperty
  a_cell_pins: assert property (p_cell_pins)
    else $error("transmit octet not on cell lanes");

  property p_idle_cell;
    @(posedge mclk) disable iff (!nrst)
    (lane_mode == lanes_pkg::MODE_CELL && cell_start && !fifo_valid)
    |=> (st.tx_state == lanes_pkg::TX_CELL_IDLE && st.tx_line == `LANES_IDLE_OCTET);
  endproperty
  a_idle_cell: assert property (p_idle_cell)
    else $error("idle cell not inserted");

  property p_rx_octet;
    @(posedge mclk) disable iff (!nrst)
    (lane_mode == lanes_pkg::MODE_CELL && st.rx_take)
    |=> (rx_valid && rx_data == $past(pins_s[7:0]));
  endproperty
  a_rx_octet: assert property (p_rx_octet)
    else $error("receive octet taken wrongly");

  property p_rx_timing;
    @(posedge mclk) disable iff (!nrst)
    (lane_mode == lanes_pkg::MODE_CELL && rx_en_s) ##1
    (lane_mode == lanes_pkg::MODE_CELL) |=> rx_valid;
  endproperty
  a_rx_timing: assert property (p_rx_timing)
    else $error("receive octet not taken after enable");

  property p_tag_pins;
    @(posedge mclk) disable iff (!nrst)
    (dma_tag_pin_sel == 6'h3f)
    |=> (pin_out[15] == $past(dma_sub_block[0]) && pin_out[1] == $past(dma_sub_block[4]) &&
         pin_out[0] == $past(dma_is_receive) && pin_oe[0]);
  endproperty
  a_tag_pins: assert property (p_tag_pins)
    else $error("requester tag not on its pins");

  property p_err_tag;
    @(posedge mclk) disable iff (!nrst)
    dma_error |=> (dma_error_flag && dma_error_tag == $past(tag_now));
  endproperty
  a_err_tag: assert property (p_err_tag)
    else $error("failed transfer tag not captured");

  property p_one_function;
    @(posedge mclk) disable iff (!nrst)
    (lane_mode == lanes_pkg::MODE_CELL && dma_tag_pin_sel == 6'h00)
    |=> (pin_oe[7:0] == 8'h00);
  endproperty
  a_one_function: assert property (p_one_function)
    else $error("receive pin driven in cell mode");

  c_data_cell: cover property (@(posedge mclk) disable iff (!nrst)
    st.tx_state == lanes_pkg::TX_CELL_DATA && st.tx_octet == `LANES_CELL_LAST);
  c_rx_cell: cover property (@(posedge mclk) disable iff (!nrst) rx_cell_last);
  c_nibble_rx: cover property (@(posedge mclk) disable iff (!nrst)
    lane_mode == lanes_pkg::MODE_NIBBLE && rx_valid);
  c_err: cover property (@(posedge mclk) disable iff (!nrst) dma_error && dma_error_clear);

endmodule // comm_channel_data_lanes

// file: core/lanes_cfg.svh
// constants for the channel data lane block
`ifndef LANES_CFG_SVH
`define LANES_CFG_SVH

`define LANES_PIN_COUNT      16
`define LANES_OCTET_W        8
`define LANES_NIBBLE_W       4
`define LANES_TAG_W          6
`define LANES_SUB_BLOCK_W    5
`define LANES_FIFO_DEPTH     32

// cell framing
`define LANES_CELL_OCTETS    6'd53
`define LANES_CELL_LAST      6'd52
`define LANES_IDLE_OCTET     8'h00
`define LANES_FILL_OCTET     8'h00

// units per octet in the stream modes
`define LANES_NIBBLE_UNITS   4'h2
`define LANES_SERIAL_UNITS   4'h8

// pin index is the port bit number minus ten
`define LANES_PIN_CELL_TX_HI 15
`define LANES_PIN_CELL_TX_LO 8
`define LANES_PIN_NIB_TX_LO  8
`define LANES_PIN_SER_TX     8
`define LANES_PIN_SER_RX     7
`define LANES_PIN_NIB_RX_B0  7

// reset values
`define LANES_RST_PINS       16'h0000
`define LANES_RST_OCTET      8'h00
`define LANES_RST_COUNT      6'h00
`define LANES_RST_UNITS      4'h0
`define LANES_RST_TAG        6'h00

`endif

// file: core/lanes_pkg.sv
// types shared by the channel data lane block
package lanes_pkg;

  typedef enum logic [1:0] {
    MODE_OFF    = 2'h0,
    MODE_CELL   = 2'h1,
    MODE_NIBBLE = 2'h3,
    MODE_SERIAL = 2'h2
  } lane_mode_type;

  typedef enum logic [1:0] {
    TX_OFF       = 2'h0,
    TX_CELL_DATA = 2'h1,
    TX_CELL_IDLE = 2'h3,
    TX_STREAM    = 2'h2
  } tx_state_type;

endpackage

// file: core/lane_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps

module lane_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             nrst,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_type;

  sync_state_type st;
  sync_state_type next_st;

  always_comb begin
    next_st.stage1 = async_in;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.stage2;

endmodule // lane_sync

// file: core/lane_fifo.sv
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps

module lane_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             nrst,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr_ptr;
    logic [AW:0]                 rd_ptr;
  } fifo_state_type;

  fifo_state_type st;
  fifo_state_type next_st;
  logic           full;
  logic           empty;

  assign empty     = (st.wr_ptr == st.rd_ptr);
  assign full      = (st.wr_ptr[AW] != st.rd_ptr[AW]) &&
                     (st.wr_ptr[AW-1:0] == st.rd_ptr[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = st.mem[st.rd_ptr[AW-1:0]];

  always_comb begin
    next_st = st;
    if (in_valid && !full) begin
      next_st.mem[st.wr_ptr[AW-1:0]] = in_data;
      next_st.wr_ptr                 = st.wr_ptr + 1'b1;
    end
    if (out_ready && !empty) begin
      next_st.rd_ptr = st.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule // lane_fifo

// file: tb/phy_model.sv
// behavioural receive-side phy facing the channel lanes
`timescale 1ns/1ps

module phy_model (
  // clock
  input  wire logic mclk,
  // receive link towards the lanes block
  output logic        rx_bus_enable,
  output logic        rx_cell_start,
  output logic [15:0] pin_in
);
  logic [8:0]  q[$];
  logic [8:0]  cur;
  logic [15:0] last;
  bit          slow;

  initial begin
    rx_bus_enable = 1'b0;
    rx_cell_start = 1'b0;
    pin_in = 16'h5a5a;
    last = 16'h5a5a;
    slow = 1'b0;
  end

  // lines carry data only in the cycle after an enable, else they invert every cycle
  always @(posedge mclk) begin
    if (rx_bus_enable && q.size() > 0) begin
      cur = q.pop_front();
      last = {~last[15:8], cur[7:0]};
      rx_cell_start <= cur[8];
    end else begin
      last = ~last;
      rx_cell_start <= 1'b0;
    end
    pin_in <= last;
    rx_bus_enable <= (q.size() > 0) && !(slow && rx_bus_enable);
  end
endmodule // phy_model

// file: tb/comm_channel_data_lanes_bench.sv
// self-checking bench for the channel data lanes block
`timescale 1ns/1ps

module comm_channel_data_lanes_bench;
  logic                     mclk, nrst, rx_bus_enable, rx_cell_start;
  lanes_pkg::lane_mode_type lane_mode;
  logic [5:0]               tag_sel, err_tag;
  logic [15:0]              pin_in, pin_out, pin_oe;
  logic                     tx_valid, tx_ready, tx_active, tx_cell_first;
  logic [7:0]               tx_data, rx_data;
  logic                     rx_valid, rx_first, rx_last, rx_error;
  logic [4:0]               sub_block;
  logic                     is_rx, dma_err, dma_clr, err_flag;
  int                       bad_count, n_checks, n_err;
  logic [9:0]               got[$];

  comm_channel_data_lanes i_dut (
    .mclk(mclk), .nrst(nrst), .lane_mode(lane_mode), .dma_tag_pin_sel(tag_sel),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .rx_bus_enable(rx_bus_enable), .rx_cell_start(rx_cell_start),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .tx_active(tx_active), .tx_cell_first(tx_cell_first),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_cell_first(rx_first),
    .rx_cell_last(rx_last), .rx_cell_error(rx_error),
    .dma_sub_block(sub_block), .dma_is_receive(is_rx), .dma_error(dma_err),
    .dma_error_clear(dma_clr), .dma_error_tag(err_tag), .dma_error_flag(err_flag)
  );

  phy_model i_phy (
    .mclk(mclk), .rx_bus_enable(rx_bus_enable), .rx_cell_start(rx_cell_start),
    .pin_in(pin_in)
  );

  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  always @(negedge mclk) begin
    if (rx_valid === 1'b1) got.push_back({rx_first, rx_last, rx_data});
    if (rx_error === 1'b1) n_err++;
  end

  function automatic logic [7:0] rev8(input logic [7:0] d);
    for (int i = 0; i < 8; i++) rev8[i] = d[7-i];
  endfunction

  task test_done;
    if (bad_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task expire(input string what);
    bad_count++;
    $display("[FAIL] %s expected done seen timeout", what);
    test_done();
  endtask

  task set_mode(input lanes_pkg::lane_mode_type m);
    @(posedge mclk) lane_mode <= m;
    @(negedge mclk);
  endtask

  task push(input logic [7:0] d);
    @(posedge mclk);
    tx_valid <= 1'b1;
    tx_data <= d;
    @(posedge mclk) tx_valid <= 1'b0;
    @(negedge mclk);
  endtask

  task wait_got(input int n);
    int k;
    k = 0;
    while (got.size() < n) begin
      @(negedge mclk);
      if (++k > 400) expire("receive");
    end
  endtask

  // fill the fifo in mode off, then it must empty as one data cell
  task fill_and_cell;
    int n, k;
    @(posedge mclk);
    tx_valid <= 1'b1;
    tx_data <= 8'h00;
    n = 0;
    for (k = 0; k < 40; k++) begin
      @(negedge mclk);
      if (tx_ready !== 1'b1) break;
      @(posedge mclk);
      n++;
      tx_data <= 8'(n * 11);
    end
    @(posedge mclk) tx_valid <= 1'b0;
    check("fifo depth", 16'(n), 16'h0020);
    set_mode(lanes_pkg::MODE_CELL);
    k = 0;
    while (tx_cell_first !== 1'b1) begin
      @(negedge mclk);
      if (++k > 20) expire("cell start");
    end
    check("cell oe", {8'h00, pin_oe[15:8]}, 16'h00ff);
    for (k = 0; k < 53; k++) begin
      check("cell octet", {8'h00, rev8(pin_out[15:8])}, {8'h00, k < 32 ? 8'(k * 11) : 8'h00});
      @(negedge mclk);
    end
    check("next cell", {15'h0000, tx_cell_first}, 16'h0001);
    check("idle octet", {8'h00, pin_out[15:8]}, 16'h0000);
    set_mode(lanes_pkg::MODE_OFF);
  endtask

  task tx_stream(input lanes_pkg::lane_mode_type m, input logic [7:0] d, input int w);
    int u, k;
    logic [3:0] mask;
    mask = (w == 4) ? 4'hf : 4'h1;
    set_mode(m);
    push(d);
    k = 0;
    while (tx_active !== 1'b1) begin
      @(negedge mclk);
      if (++k > 20) expire("stream start");
    end
    for (u = 0; u < 8 / w; u++) begin
      check("stream tx", {12'h000, pin_out[11:8] & mask}, {12'h000, 4'(d >> (u * w)) & mask});
      @(negedge mclk);
    end
    check("stream done", {15'h0000, tx_active}, 16'h0000);
    set_mode(lanes_pkg::MODE_OFF);
  endtask

  task rx_stream(input lanes_pkg::lane_mode_type m, input logic [7:0] d, input int w);
    int u;
    logic [7:0] v;
    set_mode(lanes_pkg::MODE_OFF);
    set_mode(m);
    got.delete();
    for (u = 0; u < 8 / w; u++) begin
      v = d >> (u * w);
      i_phy.q.push_back(w == 4 ? {1'b0, rev8({4'h0, v[3:0]})} : {1'b0, v[0], 7'h00});
    end
    wait_got(1);
    check("stream rx", {8'h00, got[0][7:0]}, {8'h00, d});
  endtask

  task rx_cell;
    int k;
    set_mode(lanes_pkg::MODE_CELL);
    got.delete();
    n_err = 0;
    i_phy.slow = 1'b1;
    for (k = 0; k < 53; k++) i_phy.q.push_back({k == 0, 8'(k * 5 + 3)});
    wait_got(53);
    for (k = 0; k < 53; k++)
      check("cell rx", {6'h00, got[k]}, {6'h00, k == 0, k == 52, 8'(k * 5 + 3)});
    i_phy.slow = 1'b0;
    for (k = 0; k < 5; k++) i_phy.q.push_back({k == 0 || k == 3, 8'h11});
    wait_got(58);
    check("cell error", 16'(n_err), 16'h0001);
  endtask

  task dma_tag;
    @(posedge mclk);
    tag_sel <= 6'h3f;
    sub_block <= 5'h03;
    is_rx <= 1'b1;
    dma_err <= 1'b1;
    @(posedge mclk) dma_err <= 1'b0;
    @(negedge mclk);
    check("error tag", {10'h000, err_tag}, 16'h0023);
    check("tag pins", {10'h000, pin_out[0], pin_out[1], pin_out[2], pin_out[3],
                       pin_out[14], pin_out[15]}, 16'h0023);
    @(posedge mclk);
    sub_block <= 5'h1c;
    is_rx <= 1'b0;
    dma_err <= 1'b1;
    dma_clr <= 1'b1;
    @(posedge mclk);
    dma_err <= 1'b0;
    dma_clr <= 1'b0;
    @(negedge mclk);
    check("set wins", {9'h000, err_flag, err_tag}, 16'h005c);
    @(posedge mclk) dma_clr <= 1'b1;
    @(posedge mclk) dma_clr <= 1'b0;
    @(negedge mclk);
    check("flag clear", {15'h0000, err_flag}, 16'h0000);
    @(posedge mclk) tag_sel <= 6'h00;
  endtask

  initial begin
    nrst = 1'b0;
    lane_mode = lanes_pkg::MODE_OFF;
    tag_sel = 6'h00;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    sub_block = 5'h00;
    is_rx = 1'b0;
    dma_err = 1'b0;
    dma_clr = 1'b0;
    bad_count = 0;
    n_checks = 0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    @(negedge mclk);
    check("reset ready", {15'h0000, tx_ready}, 16'h0001);
    check("reset oe", pin_oe, 16'h0000);
    fill_and_cell();
    tx_stream(lanes_pkg::MODE_NIBBLE, 8'ha5, 4);
    tx_stream(lanes_pkg::MODE_SERIAL, 8'h96, 1);
    rx_cell();
    i_phy.slow = 1'b1;
    rx_stream(lanes_pkg::MODE_NIBBLE, 8'h3c, 4);
    i_phy.slow = 1'b0;
    rx_stream(lanes_pkg::MODE_SERIAL, 8'h69, 1);
    dma_tag();
    test_done();
  end
endmodule // comm_channel_data_lanes_bench
